// ==== hw/event_counter_pkg.sv ====
/*
 * Constants for the dual event counter block: register indices and byte
 * addresses, control bit positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package event_counter_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_MARGIN_NS = 500;
    localparam int PULSE_MIN_CYCLES = 2 + (PULSE_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Register map
    // ****************************************
    localparam int IDX_RTC_CTRL = 'h20;
    localparam int IDX_CTRL = 'h40;
    localparam int IDX_C1_LOW = 'h41;
    localparam int IDX_C1_HIGH = 'h42;
    localparam int IDX_C2_LOW = 'h43;
    localparam int IDX_C2_HIGH = 'h44;
    localparam logic [11:0] ADDR_RTC_CTRL = 12'(IDX_RTC_CTRL * 4);
    localparam logic [11:0] ADDR_CTRL = 12'(IDX_CTRL * 4);
    localparam logic [11:0] ADDR_C1_LOW = 12'(IDX_C1_LOW * 4);
    localparam logic [11:0] ADDR_C1_HIGH = 12'(IDX_C1_HIGH * 4);
    localparam logic [11:0] ADDR_C2_LOW = 12'(IDX_C2_LOW * 4);
    localparam logic [11:0] ADDR_C2_HIGH = 12'(IDX_C2_HIGH * 4);

    // ****************************************
    // Control fields
    // ****************************************
    localparam int BIT_RUN_ONE = 7;
    localparam int BIT_IEN_ONE = 6;
    localparam int BIT_FLAG_ONE = 4;
    localparam int BIT_RUN_TWO = 3;
    localparam int BIT_IEN_TWO = 2;
    localparam int BIT_FLAG_TWO = 0;
    localparam int BIT_RTC_FLAG = 1;
    localparam int BIT_RTC_IEN = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] RTC_RESET = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ==== hw/pulse_edge_sync.sv ====
/*
 * Three-stage synchroniser with falling edge detection for a pin input.
 * Assumes the pin is asynchronous to mclk; a change counts once stages
 * two and three agree.
 */
`timescale 1ns/1ps
module pulse_edge_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic levelOut,
    output logic fallPulse
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    logic fall_reg;

    // ****************************************
    // Synchroniser chain
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
            stage3_reg <= 1'b1;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // ****************************************
    // Settled level and falling edge
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= 1'b1;
            fall_reg <= 1'b0;
        end else begin
            fall_reg <= (stage2_reg == stage3_reg) && !stage3_reg && level_reg;
            if (stage2_reg == stage3_reg) begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign levelOut = level_reg;
    assign fallPulse = fall_reg;

    one_fall_a: assert property (@(posedge mclk) disable iff (!rst_n) fall_reg |=> !fall_reg)
        else $error("falling edge reported twice");

endmodule

// ==== hw/event_counter_unit.sv ====
/*
 * One 16-bit event counter with byte-wide load and overflow detection.
 * Assumes one-cycle edge pulses and byte write strobes on mclk.
 */
`timescale 1ns/1ps
module event_counter_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic runEnable,
    input wire logic irqEnable,
    input wire logic fallEdge,
    input wire logic writeLow,
    input wire logic writeHigh,
    input wire logic [7:0] writeByte,
    output logic [15:0] countValue,
    output logic overflowSet
);

    logic [15:0] count_reg;
    logic suppress_reg;
    logic stepNow;
    logic wrapNow;

    // A write takes the cycle; an edge in it is lost
    assign stepNow = runEnable && fallEdge && !writeLow && !writeHigh;
    assign wrapNow = stepNow && (count_reg == event_counter_pkg::COUNT_MAX);
    assign overflowSet = wrapNow && irqEnable && !suppress_reg;

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= event_counter_pkg::COUNT_RESET;
        end else if (writeLow) begin
            count_reg[7:0] <= writeByte;
        end else if (writeHigh) begin
            count_reg[15:8] <= writeByte;
        end else if (stepNow) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ****************************************
    // Zero reached by wrap or reset
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            suppress_reg <= 1'b1;
        end else if (stepNow) begin
            suppress_reg <= wrapNow;
        end
    end

    assign countValue = count_reg;

    wrap_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (suppress_reg && wrapNow) |-> !overflowSet)
        else $error("overflow flagged after preset from reset or wrap zero");

endmodule

// ==== hw/dual_event_counter.sv ====
/*
 * Dual event counter with control register, clock tick flag and interrupt
 * combining, reached over an AHB-Lite slave. Assumes one slave on the bus
 * (hready equals hreadyout), core status inputs synchronous to mclk and a
 * one-cycle tick pulse from the clock divider on mclk.
 */
`timescale 1ns/1ps
module dual_event_counter (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic countOnePulseIn,
    input wire logic countTwoPulseIn,
    input wire logic externalIrqPin,
    input wire logic rtcTickEvent,
    input wire logic extIrqEnable,
    input wire logic inService,
    input wire logic idleMode,
    input wire logic stopMode,
    output logic irqToCore,
    output logic derivIrqService,
    output logic wakeUp
);

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [1:0] rtc_reg;
    logic [1:0] rtc_next;
    logic wrPend_reg;
    logic rdPend_reg;
    logic [11:0] addr_reg;
    logic addrHigh_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic irqToCore_reg;
    logic derivService_reg;
    logic wakeUp_reg;
    logic addrPhase;
    logic wrCtrl;
    logic wrRtc;
    logic [7:0] wByte;
    logic [7:0] readByte;
    logic [1:0] fallEdge;
    logic [1:0] pinIn;
    logic [1:0] overflowSet;
    logic [1:0] wrLow;
    logic [1:0] wrHigh;
    logic [15:0] countVal [2];
    logic extLevel;
    logic extPending;
    logic derivReq;

    // ****************************************
    // AHB-Lite address phase capture
    // ****************************************
    assign addrPhase = hsel && htrans[1] && hready;
    assign wByte = hwdata[7:0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg <= 12'h000;
            addrHigh_reg <= 1'b0;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            rdPend_reg <= addrPhase && !hwrite;
            if (addrPhase) begin
                addr_reg <= {haddr[11:2], 2'h0};
                addrHigh_reg <= |haddr[31:12];
            end
        end
    end

    // Reads wait one cycle so a write just before is visible
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_reg <= 1'b1;
            hrdata_reg <= event_counter_pkg::DATA_ZERO;
        end else begin
            hreadyout_reg <= !(addrPhase && !hwrite);
            if (rdPend_reg) begin
                hrdata_reg <= {24'h000000, readByte};
            end
        end
    end

    always_comb begin
        readByte = 8'h00;
        if (!addrHigh_reg) begin
            unique case (addr_reg)
                event_counter_pkg::ADDR_CTRL: readByte = ctrl_reg;
                event_counter_pkg::ADDR_RTC_CTRL: readByte = {6'h00, rtc_reg};
                event_counter_pkg::ADDR_C1_LOW: readByte = countVal[0][7:0];
                event_counter_pkg::ADDR_C1_HIGH: readByte = countVal[0][15:8];
                event_counter_pkg::ADDR_C2_LOW: readByte = countVal[1][7:0];
                event_counter_pkg::ADDR_C2_HIGH: readByte = countVal[1][15:8];
                default: readByte = 8'h00;
            endcase
        end
    end

    assign wrCtrl = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_CTRL);
    assign wrRtc = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_RTC_CTRL);
    assign wrLow[0] = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_C1_LOW);
    assign wrHigh[0] = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_C1_HIGH);
    assign wrLow[1] = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_C2_LOW);
    assign wrHigh[1] = wrPend_reg && !addrHigh_reg && (addr_reg == event_counter_pkg::ADDR_C2_HIGH);

    // ****************************************
    // Counter channels
    // ****************************************
    assign pinIn[0] = countOnePulseIn;
    assign pinIn[1] = countTwoPulseIn;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : gen_chan
            localparam int RUN_BIT = (ch == 0) ? event_counter_pkg::BIT_RUN_ONE : event_counter_pkg::BIT_RUN_TWO;
            localparam int IEN_BIT = (ch == 0) ? event_counter_pkg::BIT_IEN_ONE : event_counter_pkg::BIT_IEN_TWO;
            pulse_edge_sync u_sync (
                .mclk(mclk),
                .rst_n(rst_n),
                .pinIn(pinIn[ch]),
                .levelOut(),
                .fallPulse(fallEdge[ch])
            );
            event_counter_unit u_count (
                .mclk(mclk),
                .rst_n(rst_n),
                .runEnable(ctrl_reg[RUN_BIT]),
                .irqEnable(ctrl_reg[IEN_BIT]),
                .fallEdge(fallEdge[ch]),
                .writeLow(wrLow[ch]),
                .writeHigh(wrHigh[ch]),
                .writeByte(wByte),
                .countValue(countVal[ch]),
                .overflowSet(overflowSet[ch])
            );
        end
    endgenerate

    // ****************************************
    // Counter control register
    // ****************************************
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wrCtrl) begin
            ctrl_next[event_counter_pkg::BIT_RUN_ONE] = wByte[event_counter_pkg::BIT_RUN_ONE];
            ctrl_next[event_counter_pkg::BIT_IEN_ONE] = wByte[event_counter_pkg::BIT_IEN_ONE];
            ctrl_next[event_counter_pkg::BIT_RUN_TWO] = wByte[event_counter_pkg::BIT_RUN_TWO];
            ctrl_next[event_counter_pkg::BIT_IEN_TWO] = wByte[event_counter_pkg::BIT_IEN_TWO];
            ctrl_next[event_counter_pkg::BIT_FLAG_ONE] = wByte[event_counter_pkg::BIT_FLAG_ONE];
            ctrl_next[event_counter_pkg::BIT_FLAG_TWO] = wByte[event_counter_pkg::BIT_FLAG_TWO];
        end
        // Hardware set wins over a software clear
        if (overflowSet[0]) begin
            ctrl_next[event_counter_pkg::BIT_FLAG_ONE] = 1'b1;
        end
        if (overflowSet[1]) begin
            ctrl_next[event_counter_pkg::BIT_FLAG_TWO] = 1'b1;
        end
        ctrl_next[5] = 1'b0;
        ctrl_next[1] = 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= event_counter_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // Clock tick flag and enable
    // ****************************************
    always_comb begin
        rtc_next = rtc_reg;
        if (wrRtc) begin
            rtc_next[event_counter_pkg::BIT_RTC_IEN] = wByte[event_counter_pkg::BIT_RTC_IEN];
            rtc_next[event_counter_pkg::BIT_RTC_FLAG] = wByte[event_counter_pkg::BIT_RTC_FLAG];
        end
        if (rtcTickEvent) begin
            rtc_next[event_counter_pkg::BIT_RTC_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_reg <= event_counter_pkg::RTC_RESET;
        end else begin
            rtc_reg <= rtc_next;
        end
    end

    // ****************************************
    // Interrupt combining and wake
    // ****************************************
    // Pin idles low; inverted so the high reset level of the chain means no request
    pulse_edge_sync u_ext_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(!externalIrqPin),
        .levelOut(extLevel),
        .fallPulse()
    );

    assign extPending = !extLevel;
    assign derivReq = (ctrl_reg[event_counter_pkg::BIT_FLAG_ONE] && ctrl_reg[event_counter_pkg::BIT_IEN_ONE])
        || (ctrl_reg[event_counter_pkg::BIT_FLAG_TWO] && ctrl_reg[event_counter_pkg::BIT_IEN_TWO])
        || (rtc_reg[event_counter_pkg::BIT_RTC_FLAG] && rtc_reg[event_counter_pkg::BIT_RTC_IEN]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqToCore_reg <= 1'b0;
            derivService_reg <= 1'b0;
            wakeUp_reg <= 1'b0;
        end else begin
            irqToCore_reg <= extIrqEnable && !inService && (extPending || derivReq);
            derivService_reg <= extIrqEnable && !inService && !extPending && derivReq;
            wakeUp_reg <= (idleMode || stopMode) && derivReq;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign irqToCore = irqToCore_reg;
    assign derivIrqService = derivService_reg;
    assign wakeUp = wakeUp_reg;

    // ****************************************
    // Checks
    // ****************************************
    run_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ctrl_reg[event_counter_pkg::BIT_RUN_ONE] && !wrLow[0] && !wrHigh[0]) |=> $stable(countVal[0]))
        else $error("counter one moved while stopped");
    count_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_reg[event_counter_pkg::BIT_RUN_TWO] && fallEdge[1] && !wrLow[1] && !wrHigh[1])
        |=> countVal[1] == $past(countVal[1]) + 16'h0001)
        else $error("counter two did not step by one");
    spare_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_reg[5] == 1'b0) && (ctrl_reg[1] == 1'b0))
        else $error("unused control bits not zero");
    flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        overflowSet[0] |=> ctrl_reg[event_counter_pkg::BIT_FLAG_ONE])
        else $error("overflow did not raise flag one");
    flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_reg[event_counter_pkg::BIT_FLAG_TWO] && !wrCtrl) |=> ctrl_reg[event_counter_pkg::BIT_FLAG_TWO])
        else $error("flag two cleared without software");
    soft_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrRtc && wByte[event_counter_pkg::BIT_RTC_FLAG] && rtc_reg[event_counter_pkg::BIT_RTC_IEN]
        && wByte[event_counter_pkg::BIT_RTC_IEN] && extIrqEnable && !inService) ##1 (extIrqEnable && !inService)
        |=> irqToCore_reg)
        else $error("software tick did not interrupt");
    irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        irqToCore_reg |-> $past(extIrqEnable) && !$past(inService))
        else $error("interrupt passed while external interrupt disabled");
    wake_event_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (stopMode && derivReq) |=> wakeUp_reg)
        else $error("enabled event did not wake");
    serve_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
        derivService_reg |-> !$past(extPending) && $past(derivReq))
        else $error("derivative served with external pending");
    read_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (addrPhase && !hwrite) |=> !hreadyout_reg ##1 hreadyout_reg)
        else $error("read data phase not two cycles");
    ext_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (extIrqEnable && !inService && extPending) |=> irqToCore_reg)
        else $error("external request did not reach the core");
    serve_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
        inService |=> !irqToCore_reg && !derivService_reg)
        else $error("interrupt passed while a routine runs");
    reset_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |=> !irqToCore_reg && !derivService_reg && !wakeUp_reg)
        else $error("request raised right after reset");
    tick_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rtcTickEvent |=> rtc_reg[event_counter_pkg::BIT_RTC_FLAG])
        else $error("tick did not raise the tick flag");
    wake_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (idleMode && derivReq) |=> wakeUp_reg)
        else $error("enabled event did not end idle");
    flag_two_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        overflowSet[1] |=> ctrl_reg[event_counter_pkg::BIT_FLAG_TWO])
        else $error("overflow did not raise flag two");
    run_two_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ctrl_reg[event_counter_pkg::BIT_RUN_TWO] && !wrLow[1] && !wrHigh[1]) |=> $stable(countVal[1]))
        else $error("counter two moved while stopped");

    wrap_cov: cover property (@(posedge mclk) disable iff (!rst_n) overflowSet[1]);
    wake_cov: cover property (@(posedge mclk) disable iff (!rst_n) wakeUp_reg);
    serve_cov: cover property (@(posedge mclk) disable iff (!rst_n) derivService_reg);
    tick_cov: cover property (@(posedge mclk) disable iff (!rst_n) rtcTickEvent);
    ext_cov: cover property (@(posedge mclk) disable iff (!rst_n) irqToCore_reg && extPending);

endmodule

// ==== bench/pulse_source.sv ====
/*
 * Far-side pulse source for one count input: bursts of falling edges.
 * Assumes mclk at 100 MHz; one pulse per 100 cycles (1 MHz), idle high.
 */
`timescale 1ns/1ps
module pulse_source (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic burstGo,
    input wire logic [3:0] burstLen,
    output logic pulseOut,
    output logic busy
);
    logic [6:0] phaseCnt;
    logic [3:0] remaining;
    // ****************************************
    // Burst generator
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pulseOut <= 1'b1;
            remaining <= 4'h0;
            phaseCnt <= 7'h00;
        end else if (burstGo && remaining == 4'h0) begin
            remaining <= burstLen;
            phaseCnt <= 7'h00;
        end else if (remaining != 4'h0) begin
            phaseCnt <= (phaseCnt == 7'd99) ? 7'h00 : phaseCnt + 7'h01;
            pulseOut <= (phaseCnt < 7'd50) ? 1'b0 : 1'b1;
            if (phaseCnt == 7'd99) begin
                remaining <= remaining - 4'h1;
            end
        end
    end
    assign busy = (remaining != 4'h0);
endmodule

// ==== bench/test_dual_event_counter.sv ====
/*
 * Self-checking bench for the dual event counter over AHB-Lite.
 * Assumes hready tied to hreadyout and two pulse sources on the pins.
 */
`timescale 1ns/1ps
module test_dual_event_counter;
    logic mclk, rst_n, hsel, hwrite, extIrqEnable, inService, idleMode, stopMode;
    logic rtcTickEvent, externalIrqPin, hreadyout, hresp, irqToCore, derivIrqService, wakeUp;
    logic [31:0] haddr, hwdata, hrdata, rdVal;
    logic [1:0] htrans, pulseIn, srcBusy, burstGo;
    logic [2:0] hsize;
    logic [3:0] burstLen [2];
    logic [11:0] lowAddr [2] = '{event_counter_pkg::ADDR_C1_LOW, event_counter_pkg::ADDR_C2_LOW};
    logic [11:0] highAddr [2] = '{event_counter_pkg::ADDR_C1_HIGH, event_counter_pkg::ADDR_C2_HIGH};
    int runPos [2] = '{event_counter_pkg::BIT_RUN_ONE, event_counter_pkg::BIT_RUN_TWO};
    int badCount, samplesChecked, cycles, ctrl;
    int cnt [2];
    logic [31:0] seedVal;
    dual_event_counter dual_event_counter_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .countOnePulseIn(pulseIn[0]),
        .countTwoPulseIn(pulseIn[1]), .externalIrqPin(externalIrqPin), .rtcTickEvent(rtcTickEvent),
        .extIrqEnable(extIrqEnable), .inService(inService), .idleMode(idleMode), .stopMode(stopMode),
        .irqToCore(irqToCore), .derivIrqService(derivIrqService), .wakeUp(wakeUp));
    pulse_source srcOne (.mclk(mclk), .rst_n(rst_n), .burstGo(burstGo[0]), .burstLen(burstLen[0]),
        .pulseOut(pulseIn[0]), .busy(srcBusy[0]));
    pulse_source srcTwo (.mclk(mclk), .rst_n(rst_n), .burstGo(burstGo[1]), .burstLen(burstLen[1]),
        .pulseOut(pulseIn[1]), .busy(srcBusy[1]));
    // ****************************************
    // Clock, timeout and verdict
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            conclude();
        end
    end
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic busCycle(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h00000, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rdVal = hrdata;
    endtask
    task automatic readCheck(input string what, input logic [11:0] a, input logic [31:0] exp);
        busCycle(1'b0, a, 8'h00);
        compare(what, exp, rdVal);
        compare("response", 32'(event_counter_pkg::HRESP_OKAY), {31'h0, hresp});
    endtask
    task automatic setCtrl(input logic [7:0] v);
        ctrl = v & 8'hdd;
        busCycle(1'b1, event_counter_pkg::ADDR_CTRL, v);
    endtask
    task automatic writeCount(input int i, input logic [15:0] v);
        busCycle(1'b1, lowAddr[i], v[7:0]);
        busCycle(1'b1, highAddr[i], v[15:8]);
        cnt[i] = v;
    endtask
    task automatic checkCounts();
        logic [7:0] lo;
        for (int i = 0; i < 2; i++) begin
            busCycle(1'b0, lowAddr[i], 8'h00);
            lo = rdVal[7:0];
            busCycle(1'b0, highAddr[i], 8'h00);
            compare("counter", 32'(cnt[i]), {rdVal[23:0], lo});
        end
    endtask
    task automatic pulses(input int n0, input int n1);
        @(posedge mclk);
        burstGo <= 2'b11;
        burstLen[0] <= 4'(n0);
        burstLen[1] <= 4'(n1);
        @(posedge mclk);
        burstGo <= 2'b00;
        @(posedge mclk);
        while (srcBusy !== 2'b00) @(posedge mclk);
        repeat (8) @(posedge mclk);
        if (ctrl[runPos[0]]) cnt[0] = (cnt[0] + n0) & 'hffff;
        if (ctrl[runPos[1]]) cnt[1] = (cnt[1] + n1) & 'hffff;
    endtask
    task automatic checkIrq(input logic [2:0] exp);
        repeat (6) @(posedge mclk);
        compare("irq core service wake", {29'h0, exp}, {29'h0, irqToCore, derivIrqService, wakeUp});
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst_n, hsel, hwrite, inService, idleMode, stopMode, rtcTickEvent, externalIrqPin} = '0;
        {haddr, hwdata, htrans, burstGo} = '0;
        burstLen = '{4'h0, 4'h0};
        hsize = 3'h2;
        extIrqEnable = 1'b1;
        cnt = '{0, 0};
        ctrl = 0;
        seedVal = $urandom(32'h76c257a2);
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        readCheck("control", event_counter_pkg::ADDR_CTRL, 32'h0);
        readCheck("tick control", event_counter_pkg::ADDR_RTC_CTRL, 32'h0);
        readCheck("unmapped", 12'hffc, 32'h0);
        checkCounts();
        $display("test reset done");
        setCtrl(8'h88);
        pulses(3, 5);
        checkCounts();
        setCtrl(8'h00);
        pulses(2, 2);
        checkCounts();
        $display("test counting done");
        for (int i = 0; i < 2; i++) writeCount(i, 16'($urandom));
        checkCounts();
        $display("test preset done");
        setCtrl(8'hcc);
        for (int i = 0; i < 2; i++) writeCount(i, 16'hffff);
        pulses(1, 1);
        ctrl = 8'hdd;
        readCheck("control", event_counter_pkg::ADDR_CTRL, 32'(ctrl));
        checkCounts();
        checkIrq(3'b110);
        setCtrl(8'hcc);
        readCheck("control", event_counter_pkg::ADDR_CTRL, 32'(ctrl));
        for (int i = 0; i < 2; i++) writeCount(i, 16'hffff);
        pulses(1, 1);
        readCheck("control", event_counter_pkg::ADDR_CTRL, 32'(ctrl));
        checkCounts();
        $display("test overflow done");
        setCtrl(8'hff);
        readCheck("control", event_counter_pkg::ADDR_CTRL, 32'(ctrl));
        checkIrq(3'b110);
        extIrqEnable <= 1'b0;
        checkIrq(3'b000);
        extIrqEnable <= 1'b1;
        inService <= 1'b1;
        checkIrq(3'b000);
        inService <= 1'b0;
        externalIrqPin <= 1'b1;
        checkIrq(3'b100);
        externalIrqPin <= 1'b0;
        idleMode <= 1'b1;
        checkIrq(3'b111);
        idleMode <= 1'b0;
        stopMode <= 1'b1;
        checkIrq(3'b111);
        setCtrl(8'h88);
        checkIrq(3'b000);
        stopMode <= 1'b0;
        $display("test interrupts done");
        busCycle(1'b1, event_counter_pkg::ADDR_RTC_CTRL, 8'h01);
        @(posedge mclk);
        rtcTickEvent <= 1'b1;
        @(posedge mclk);
        rtcTickEvent <= 1'b0;
        readCheck("tick control", event_counter_pkg::ADDR_RTC_CTRL, 32'h3);
        checkIrq(3'b110);
        busCycle(1'b1, event_counter_pkg::ADDR_RTC_CTRL, 8'h00);
        readCheck("tick control", event_counter_pkg::ADDR_RTC_CTRL, 32'h0);
        busCycle(1'b1, event_counter_pkg::ADDR_RTC_CTRL, 8'h01);
        busCycle(1'b1, event_counter_pkg::ADDR_RTC_CTRL, 8'h03);
        checkIrq(3'b110);
        readCheck("tick control", event_counter_pkg::ADDR_RTC_CTRL, 32'h3);
        $display("test tick done");
        conclude();
    end
endmodule
